// file: pkg/usisc_pkg.sv
// Constants, types and register map of the serial shift/counter core
// How it works
// - External clock source counts on both rising and falling edges.
// - Counter preset to F overflows on the next external edge.
// - Counter can be clocked by timer zero match to extend it.
// - Data register accesses read and write the live shift register.
// - Data write in a shift cycle keeps written value and drops shift.
// - Shift left one bit per clock from external, timer or software.
// - Data and clock inputs work whatever the wire mode.
// - Data pin is fed from shift bit seven through an output latch.
// - Latch open first half of external clock, always open otherwise.
// - Open latch passes new top bit; sample and change on opposite edges.
// - Data pin is driven only when its direction bit is one.
// - Start flag from start condition in two-wire, else from each count.
// - Start flag clears by written one, frees clock hold, may interrupt.
// - Overflow flag sets when counter wraps from fifteen to zero.
// - Overflow flag clears by writing one, releasing overflow clock hold.
// - Stop flag sets on stop condition in two-wire, cleared by one.
// - Collision bit reads one when shift bit seven differs from the pin.
// - Status low four bits show counter, readable and writable.
// - Counter counts each clock of the selected source or software strobe.
// - External source plus shift strobe lets toggle strobe make a clock.
// - Start enable gates start interrupt, pending flag fires at once.
// - Overflow enable gates its interrupt, pending flag fires at once.
// - Wire mode: off, three-wire, two-wire, two-wire with overflow hold.
// - Two-wire data pulled low when shift output or port bit is zero.
package usisc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;

    localparam int ST_START  = 7;
    localparam int ST_OVF    = 6;
    localparam int ST_STOP   = 5;
    localparam int ST_COLL   = 4;
    localparam int CR_SIE    = 7;
    localparam int CR_OIE    = 6;
    localparam int CR_WM_LO  = 4;
    localparam int CR_CS_LO  = 2;
    localparam int CR_CLK    = 1;
    localparam int CR_TC     = 0;

    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [3:0] RST_CNT  = 4'h0;
    localparam logic [3:0] CNT_MAX  = 4'hf;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WM_OFF      = 2'b00,
        WM_THREE    = 2'b01,
        WM_TWO      = 2'b10,
        WM_TWO_HOLD = 2'b11
    } usisc_wm_e;

    typedef enum logic [1:0] {
        CS_SOFT    = 2'b00,
        CS_TIMER   = 2'b01,
        CS_EXT_POS = 2'b10,
        CS_EXT_NEG = 2'b11
    } usisc_cs_e;

endpackage : usisc_pkg

// file: hdl/usisc_pin_sync.sv
// Two-stage synchroniser and edge finder for the serial pins
module usisc_pin_sync
    import usisc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [1:0] pin_raw,
    output logic      [1:0] lvl,
    output logic      [1:0] rise,
    output logic      [1:0] fall
);

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
    } usisc_sync_s;

    usisc_sync_s st_r;
    usisc_sync_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_raw;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Edges seen only behind the second stage
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_edge
        assign lvl[i]  = st_r.s2[i];
        assign rise[i] = st_r.s2[i] & ~st_r.prev[i];
        assign fall[i] = ~st_r.s2[i] & st_r.prev[i];
    end

endmodule : usisc_pin_sync

// file: hdl/usisc_core.sv
// Serial shift register, clock counter and flags behind AXI4-Lite
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module usisc_core
    import usisc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        serial_in_pin,
    input  wire logic        serial_clock_pin,
    input  wire logic        timer0_match,
    input  wire logic        ddr_dat,
    input  wire logic        port_dat,
    input  wire logic        ddr_scl,
    input  wire logic        port_scl,
    output logic             dat_pin_o,
    output logic             dat_pin_oe_n,
    output logic             scl_pin_o,
    output logic             scl_pin_oe_n,
    output logic             clock_toggle_o,
    output logic             start_irq,
    output logic             ovf_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  shift;
        logic [3:0]  cnt;
        logic        start_f;
        logic        ovf_f;
        logic        stop_f;
        logic        sie;
        logic        oie;
        usisc_wm_e   wm;
        usisc_cs_e   cs;
        logic        latch;
        logic        dat_o;
        logic        dat_oe_n;
        logic        scl_oe_n;
        logic        toggle;
        logic        start_irq;
        logic        ovf_irq;
        logic        aw_have;
        logic [11:0] awaddr;
        logic        w_have;
        logic [7:0]  wdata;
        logic        wstb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } usisc_state_s;

    localparam usisc_state_s RST = '{
        shift: RST_DATA, cnt: RST_CNT, start_f: 1'b0, ovf_f: 1'b0,
        stop_f: 1'b0, sie: 1'b0, oie: 1'b0, wm: WM_OFF, cs: CS_SOFT,
        latch: 1'b0, dat_o: 1'b0, dat_oe_n: 1'b1, scl_oe_n: 1'b1,
        toggle: 1'b0, start_irq: 1'b0, ovf_irq: 1'b0, aw_have: 1'b0,
        awaddr: 12'h000, w_have: 1'b0, wdata: 8'h00, wstb: 1'b0,
        awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
        arready: 1'b1, rvalid: 1'b0, rdata: 8'h00, rresp: RESP_OKAY
    };

    usisc_state_s st_r;
    usisc_state_s st_nxt;

    logic [1:0] pin_lvl;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic       sda_lvl;
    logic       scl_lvl;
    logic       scl_edge;
    logic       wr_go;
    logic       wr_data;
    logic       wr_stat;
    logic       wr_ctrl;
    logic [7:0] wd;
    logic       two_wire;
    usisc_cs_e  eff_cs;
    logic       shift_clk;
    logic       cnt_clk;
    logic       start_det;
    logic       stop_det;
    logic       coll;
    logic       latch_open;
    logic       aw_map;
    logic       ar_map;
    logic [7:0] rd_val;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Inputs stay live in every wire mode
    usisc_pin_sync u_sync (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .ce      (ce),
        .pin_raw ({serial_clock_pin, serial_in_pin}),
        .lvl     (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign sda_lvl  = pin_lvl[0];
    assign scl_lvl  = pin_lvl[1];
    assign scl_edge = pin_rise[1] | pin_fall[1];

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign wd      = st_r.wdata;
    assign wr_go   = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
    assign aw_map  = (st_r.awaddr == ADDR_DATA) |
                     (st_r.awaddr == ADDR_STAT) |
                     (st_r.awaddr == ADDR_CTRL);
    assign wr_data = wr_go & st_r.wstb & (st_r.awaddr == ADDR_DATA);
    assign wr_stat = wr_go & st_r.wstb & (st_r.awaddr == ADDR_STAT);
    assign wr_ctrl = wr_go & st_r.wstb & (st_r.awaddr == ADDR_CTRL);
    assign two_wire = st_r.wm[1];

    // Strobes act with the source written in the same access
    assign eff_cs = wr_ctrl ? usisc_cs_e'(wd[CR_CS_LO+1:CR_CS_LO])
                            : st_r.cs;

    // ------------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------------
    always_comb begin
        shift_clk = 1'b0;
        cnt_clk   = 1'b0;
        unique case (eff_cs)
            CS_SOFT: begin
                shift_clk = wr_ctrl & wd[CR_CLK];
                cnt_clk   = wr_ctrl & (wd[CR_CLK] | wd[CR_TC]);
            end
            CS_TIMER: begin
                shift_clk = timer0_match;
                cnt_clk   = timer0_match;
            end
            CS_EXT_POS: begin
                shift_clk = pin_rise[1];
                cnt_clk   = scl_edge;
            end
            CS_EXT_NEG: begin
                shift_clk = pin_fall[1];
                cnt_clk   = scl_edge;
            end
        endcase
        if (eff_cs[1] && wr_ctrl && wd[CR_CLK] && wd[CR_TC]) begin
            shift_clk = 1'b1;
            cnt_clk   = 1'b1;
        end
    end

    // Start and stop: data line moves while clock is high
    assign start_det = two_wire & pin_fall[0] & scl_lvl;
    assign stop_det  = two_wire & pin_rise[0] & scl_lvl;
    assign coll      = st_r.shift[7] ^ sda_lvl;

    // Output latch closes in the second half of an external clock
    assign latch_open = ~st_r.cs[1] | (scl_lvl == st_r.cs[0]);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    assign ar_map = (araddr == ADDR_DATA) | (araddr == ADDR_STAT) |
                    (araddr == ADDR_CTRL);
    always_comb begin
        rd_val = 8'h00;
        if (araddr == ADDR_DATA) begin
            rd_val = st_r.shift;
        end else if (araddr == ADDR_STAT) begin
            rd_val = {st_r.start_f, st_r.ovf_f, st_r.stop_f, coll,
                      st_r.cnt};
        end else if (araddr == ADDR_CTRL) begin
            rd_val = {st_r.sie, st_r.oie, st_r.wm, st_r.cs, 2'b00};
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Write channel capture
        if (awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr  = {awaddr[11:2], 2'b00};
        end
        if (wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata  = wdata[7:0];
            st_nxt.wstb   = wstrb[0];
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = aw_map ? RESP_OKAY : RESP_SLVERR;
        end
        st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
        st_nxt.wready  = ~st_nxt.w_have & ~st_nxt.bvalid;

        // Read channel
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_val;
            st_nxt.rresp  = ar_map ? RESP_OKAY : RESP_SLVERR;
        end
        st_nxt.arready = ~st_nxt.rvalid;

        // Control register; strobe bits are not stored
        if (wr_ctrl) begin
            st_nxt.sie = wd[CR_SIE];
            st_nxt.oie = wd[CR_OIE];
            st_nxt.wm  = usisc_wm_e'(wd[CR_WM_LO+1:CR_WM_LO]);
            st_nxt.cs  = eff_cs;
        end
        st_nxt.toggle = wr_ctrl & wd[CR_TC];

        // Shift register: a bus write beats a coincident shift
        if (wr_data) begin
            st_nxt.shift = wd;
        end else if (shift_clk) begin
            st_nxt.shift = {st_r.shift[6:0], sda_lvl};
        end

        // Counter: a bus write beats a coincident count
        if (wr_stat) begin
            st_nxt.cnt = wd[3:0];
        end else if (cnt_clk) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end

        // Flags: start/stop detection wins over a clear in the same cycle; a status write blocks the count-driven sets
        st_nxt.start_f = (two_wire ? start_det : (cnt_clk & ~wr_stat)) |
                         (st_r.start_f &
                          ~(wr_stat & wd[ST_START]));
        st_nxt.ovf_f   = (cnt_clk & ~wr_stat & (st_r.cnt == CNT_MAX)) |
                         (st_r.ovf_f &
                          ~(wr_stat & wd[ST_OVF]));
        st_nxt.stop_f  = stop_det |
                         (st_r.stop_f & ~(wr_stat & wd[ST_STOP]));

        // Enabled flags raise the request at once, even if already pending
        st_nxt.start_irq = st_nxt.start_f & st_nxt.sie;
        st_nxt.ovf_irq   = st_nxt.ovf_f & st_nxt.oie;

        // Output latch from the top bit
        if (latch_open) begin
            st_nxt.latch = st_nxt.shift[7];
        end

        // Pin drivers by wire mode
        st_nxt.dat_o    = 1'b0;
        st_nxt.dat_oe_n = 1'b1;
        st_nxt.scl_oe_n = 1'b1;
        unique case (st_nxt.wm)
            WM_OFF: begin
                st_nxt.dat_oe_n = 1'b1;
            end
            WM_THREE: begin
                st_nxt.dat_o    = st_nxt.latch;
                st_nxt.dat_oe_n = ~ddr_dat;
            end
            WM_TWO, WM_TWO_HOLD: begin
                st_nxt.dat_oe_n = ~(ddr_dat &
                                    (~st_nxt.latch | ~port_dat));
                st_nxt.scl_oe_n = ~(ddr_scl & (~port_scl | st_nxt.start_f |
                    (st_nxt.wm[0] & st_nxt.ovf_f)));
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready        = st_r.awready;
    assign wready         = st_r.wready;
    assign bvalid         = st_r.bvalid;
    assign bresp          = st_r.bresp;
    assign arready        = st_r.arready;
    assign rvalid         = st_r.rvalid;
    assign rresp          = st_r.rresp;
    assign rdata          = {24'h000000, st_r.rdata};
    assign dat_pin_o      = st_r.dat_o;
    assign dat_pin_oe_n   = st_r.dat_oe_n;
    assign scl_pin_o      = 1'b0;
    assign scl_pin_oe_n   = st_r.scl_oe_n;
    assign clock_toggle_o = st_r.toggle;
    assign start_irq      = st_r.start_irq;
    assign ovf_irq        = st_r.ovf_irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_OVF_WRAP: assert property (ce && cnt_clk && !wr_stat &&
        st_r.cnt == 4'hf |=> st_r.ovf_f && st_r.cnt == 4'h0)
        else $error("overflow not set on wrap");
    AST_WRITE_WINS: assert property (ce && wr_data
        |=> st_r.shift == $past(wd))
        else $error("data write lost to shift");
    AST_SHIFT_LEFT: assert property (ce && shift_clk && !wr_data
        |=> st_r.shift == {$past(st_r.shift[6:0]), $past(sda_lvl)})
        else $error("shift not left by one");
    AST_BOTH_EDGES: assert property (ce && st_r.cs[1] && scl_edge &&
        !wr_stat && !wr_ctrl
        |=> st_r.cnt == $past(st_r.cnt) + 4'h1)
        else $error("external edge not counted");
    AST_OVF_STICKY: assert property (ce && st_r.ovf_f &&
        !(wr_stat && wd[ST_OVF]) |=> st_r.ovf_f)
        else $error("overflow flag dropped");
    AST_START_IRQ: assert property (ce && wr_ctrl && wd[CR_SIE] &&
        st_r.start_f |=> start_irq)
        else $error("pending start not signalled");
    AST_LATCH_HOLD: assert property (ce && st_r.cs[1] &&
        scl_lvl != st_r.cs[0] |=> st_r.latch == $past(st_r.latch))
        else $error("latch moved while closed");
    AST_DDR_GATE: assert property (ce && !ddr_dat
        |=> dat_pin_oe_n)
        else $error("data pin driven without direction");
    AST_STOP_SET: assert property (ce && stop_det |=> st_r.stop_f)
        else $error("stop flag not set");
    AST_START_COUNT: assert property (ce && !two_wire && cnt_clk &&
        !wr_stat |=> st_r.start_f)
        else $error("start flag not set on count");

endmodule : usisc_core

// file: verification/usisc_serial_master.sv
// Far-side serial master: drives the data and clock pins
module usisc_serial_master (
    output logic sclk,
    output logic sdat
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        sdat = 1'b0;
    end

    // ------------------------------------------------------------------
    // Frame: data set in the low half, clock stands low between frames
    // ------------------------------------------------------------------
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sdat = b[7-i];
            #8;
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
            #8;
        end
        // Released line has no pull, so show the inverse of the last bit
        sdat = ~sdat;
    endtask : send

    // Start (data falls) or stop (data rises) while the clock stands high
    task automatic mark(input logic stop);
        sdat = ~stop;
        #8;
        sclk = 1'b1;
        #16;
        sdat = stop;
        #16;
        sclk = 1'b0;
        #8;
    endtask : mark
endmodule : usisc_serial_master

// file: verification/usisc_core_tb.sv
// Self-checking testbench of the serial shift/counter core
module usisc_core_tb;
    import usisc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, timer0_match = 0, ddr_dat = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, dat_pin_o, dat_pin_oe_n;
    logic start_irq, ovf_irq, sclk, sdat, scl_oe_n, clk_tog, ddr_scl = 0;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rd_d, rd_d_w;
    int num_errors = 0, n_compared = 0;
    // Rows: address, written value, value read back
    logic [11:0] row_a [6] = '{ADDR_DATA, ADDR_STAT, ADDR_CTRL, ADDR_CTRL,
                               ADDR_CTRL, ADDR_CTRL};
    logic [7:0]  row_w [6] = '{8'ha5, 8'h0c, 8'hfc, 8'h10, 8'h20, 8'h00};
    logic [7:0]  row_x [6] = '{8'ha5, 8'h1c, 8'hfc, 8'h10, 8'h20, 8'h00};

    always #2 mclk = ~mclk;

    usisc_serial_master u_usisc_serial_master (.sclk(sclk), .sdat(sdat));

    usisc_core u_usisc_core (
        .mclk(mclk), .arst_n(arst_n), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rd_d_w), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_in_pin(sdat), .serial_clock_pin(sclk),
        .timer0_match(timer0_match), .ddr_dat(ddr_dat), .port_dat(1'b1),
        .ddr_scl(ddr_scl), .port_scl(1'b1), .dat_pin_o(dat_pin_o),
        .dat_pin_oe_n(dat_pin_oe_n), .scl_pin_o(), .scl_pin_oe_n(scl_oe_n),
        .clock_toggle_o(clk_tog), .start_irq(start_irq), .ovf_irq(ovf_irq)
    );

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && !awvalid && !wvalid));
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && !arvalid));
        rd_d = rd_d_w;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Collision bit masked: it follows a pin level the bench does not fix
    task automatic chk_stat(input logic [7:0] exp);
        rd(ADDR_STAT);
        chk(rd_d & 32'hef, {24'h0, exp & 8'hef});
    endtask : chk_stat

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        #100000;
        num_errors++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (row_a[i]) begin
            rd(row_a[i]);
            chk(rd_d, 32'h0);
        end
        $display("test reset done");
        foreach (row_a[i]) begin
            wr(row_a[i], row_w[i]);
            rd(row_a[i]);
            chk(rd_d, {24'h0, row_x[i]});
        end
        $display("test table done");
        wr(12'h00c, 8'h01);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(12'h00c);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("test unmapped done");
        // Software strobes in three-wire mode
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_DATA, 8'ha5);
        wr(ADDR_STAT, 8'he0);
        wr(ADDR_CTRL, 8'h12);
        rd(ADDR_DATA);
        chk(rd_d & 32'hfe, 32'h4a);
        chk_stat(8'h81);
        wr(ADDR_STAT, 8'h0f);
        wr(ADDR_CTRL, 8'h11);
        chk_stat(8'hc0);
        wr(ADDR_CTRL, 8'h50);
        repeat (2) @(posedge mclk);
        chk({31'h0, ovf_irq}, 32'h1);
        wr(ADDR_STAT, 8'h40);
        repeat (2) @(posedge mclk);
        chk({31'h0, ovf_irq}, 32'h0);
        wr(ADDR_CTRL, 8'h90);
        repeat (2) @(posedge mclk);
        chk({31'h0, start_irq}, 32'h1);
        wr(ADDR_STAT, 8'h80);
        repeat (2) @(posedge mclk);
        chk({31'h0, start_irq}, 32'h0);
        $display("test strobe done");
        // Output latch open with internal source
        ddr_dat <= 1'b1;
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_DATA, 8'h80);
        repeat (2) @(posedge mclk);
        chk({30'h0, dat_pin_o, dat_pin_oe_n}, 32'h2);
        wr(ADDR_DATA, 8'h00);
        repeat (2) @(posedge mclk);
        chk({31'h0, dat_pin_o}, 32'h0);
        ddr_dat <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, dat_pin_oe_n}, 32'h1);
        $display("test output done");
        // External clock with no wire mode: both edges count
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_DATA, 8'h00);
        wr(ADDR_STAT, 8'he0);
        u_usisc_serial_master.send(8'hc3, 8);
        repeat (8) @(posedge mclk);
        rd(ADDR_DATA);
        chk(rd_d, 32'hc3);
        chk_stat(8'hc0);
        wr(ADDR_STAT, 8'hef);
        u_usisc_serial_master.send(8'h00, 1);
        repeat (8) @(posedge mclk);
        chk_stat(8'hc1);
        $display("test external done");
        // Timer zero match as the source
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_STAT, 8'he3);
        @(posedge mclk);
        timer0_match <= 1'b1;
        @(posedge mclk);
        timer0_match <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_stat(8'h84);
        $display("test timer done");
        // External source: shift strobe with toggle strobe makes one clock
        wr(ADDR_STAT, 8'he0);
        wr(ADDR_CTRL, 8'h0b);
        chk({31'h0, clk_tog}, 32'h1);
        chk_stat(8'h81);
        $display("test toggle done");
        // Two-wire: a start holds the clock line, a stop only flags
        wr(ADDR_CTRL, 8'h20);
        wr(ADDR_STAT, 8'he0);
        ddr_scl <= 1'b1;
        u_usisc_serial_master.mark(1'b0);
        repeat (8) @(posedge mclk);
        chk_stat(8'h80);
        chk({31'h0, scl_oe_n}, 32'h0);
        wr(ADDR_STAT, 8'h80);
        repeat (2) @(posedge mclk);
        chk({31'h0, scl_oe_n}, 32'h1);
        u_usisc_serial_master.mark(1'b1);
        repeat (8) @(posedge mclk);
        chk_stat(8'h20);
        $display("test two-wire done");
        results();
    end
endmodule : usisc_core_tb
